/* File: src/himfi_pkg.sv */
// package for the interrupt mask / frame period register bank
// assumes an apb slave on pclk; offsets are printed command indexes times four
package himfi_pkg;

  // printed register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_MASK_RD      = 8'h04;
  localparam logic [7:0]  IDX_MASK_CLR_RD  = 8'h05;
  localparam logic [7:0]  IDX_PERIOD_RD    = 8'h0D;
  localparam logic [7:0]  IDX_MASK_SET_WR  = 8'h84;
  localparam logic [7:0]  IDX_MASK_CLR_WR  = 8'h85;
  localparam logic [7:0]  IDX_PERIOD_WR    = 8'h8D;
  localparam logic [7:0]  IDX_CONTROL      = 8'hC0;
  localparam logic [7:0]  IDX_EVENTS       = 8'hC1;

  // field positions
  localparam int          MASTER_BIT       = 31;
  localparam int          TOGGLE_BIT       = 31;
  localparam int          BUDGET_LSB       = 16;
  localparam int          PERIOD_LSB       = 0;

  // writable bits of the shared mask: master, events 6..2 and 0
  localparam logic [31:0] MASK_VALID       = 32'h8000007D;
  localparam logic [31:0] PERIOD_VALID     = 32'hFFFF3FFF;

  // reset values
  localparam logic [31:0] MASK_RESET       = 32'h80000000;
  localparam logic [13:0] PERIOD_DEFAULT   = 14'h2EDF;
  localparam logic [31:0] PERIOD_RESET     = 32'h00002EDF;

  // frame period config as carried to the frame logic
  typedef struct packed {
    logic        toggle;
    logic [14:0] budget;
    logic [1:0]  unused;
    logic [13:0] period;
  } himfi_period_type;

endpackage : himfi_pkg

/* File: src/himfi_regs.sv */
// interrupt mask with set/clear views, frame period config and a small frame countdown
// assumes an apb master on pclk; bit_tick and event flags come from the host core
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns

// Summary of operation
// [R1] writing 1 on the clear view clears that mask bit
// [R2] writing 0 on the clear view leaves the mask bit unchanged
// [R3] reading the clear view returns the live mask
// [R4] indexes 05 read and 85 write reach the same mask
// [R5] mask bits 6,5,4,3,2,0 gate their own event sources
// [R6] bit 31 one clears master enable; zero does nothing
// [R7] master enable comes up set after hardware or soft reset
// [R8] frame period config read at 0D and written at 8D
// [R9] frame period field bits 13..0, default 11999
// [R10] budget bits 30..16 loaded into packet counter at frame start
// [R11] software computes the budget; hardware stores it unchanged
// [R12] software inverts toggle bit 31 on each new period
// [R13] period rewrites accepted at any frame
// [R14] software saves period before controller reset
// [R15] controller soft reset returns period to default
// [R16] software may restore saved period after reset
// [R17] interrupt only with event flag, mask bit and master enable
// [R18] countdown at zero reloads from period at next bit time
// [R19] writing 1 on the set view sets mask bit; zero unchanged
// [R20] reserved bits ignore writes and read as zero
module himfi_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bit_tick,
  input  wire logic [6:0]  event_flags,
  input  wire logic [14:0] packet_used,
  output logic             irq_req,
  output logic [31:0]      interrupt_mask,
  output himfi_pkg::himfi_period_type frame_period_config,
  output logic [13:0]      frame_countdown,
  output logic             frame_begin,
  output logic [14:0]      packet_counter
);

  logic [31:0] mask_ff;
  logic [31:0] nxt_mask;
  logic [31:0] period_ff;
  logic [31:0] nxt_period;
  logic [13:0] count_ff;
  logic [13:0] nxt_count;
  logic [14:0] pkt_ff;
  logic [14:0] nxt_pkt;
  logic        soft_rst_ff;
  logic        begin_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        err_ff;

  // true when an aligned byte address lands on the word of a printed index;
  // misaligned addresses never hit, so they fall through to the error path
  function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
    idx_hit = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, idx});
  endfunction : idx_hit

  // address decode: access strobes and one hit per register view
  wire         setup     = psel && !penable;
  wire         wr_acc    = psel && penable && pwrite;
  wire         hit_mrd   = idx_hit(paddr, himfi_pkg::IDX_MASK_RD);
  wire         hit_mcrd  = idx_hit(paddr, himfi_pkg::IDX_MASK_CLR_RD);
  wire         hit_prd   = idx_hit(paddr, himfi_pkg::IDX_PERIOD_RD);
  wire         hit_msw   = idx_hit(paddr, himfi_pkg::IDX_MASK_SET_WR);
  wire         hit_mcw   = idx_hit(paddr, himfi_pkg::IDX_MASK_CLR_WR);
  wire         hit_pw    = idx_hit(paddr, himfi_pkg::IDX_PERIOD_WR);
  wire         hit_ctl   = idx_hit(paddr, himfi_pkg::IDX_CONTROL);
  wire         hit_evt   = idx_hit(paddr, himfi_pkg::IDX_EVENTS);
  wire         rd_hit    = hit_mrd || hit_mcrd || hit_prd || hit_ctl || hit_evt;
  wire         wr_hit    = hit_msw || hit_mcw || hit_pw || hit_ctl;
  wire         bad_acc   = pwrite ? !wr_hit : !rd_hit;
  wire         do_set    = wr_acc && hit_msw;
  wire         do_clr    = wr_acc && hit_mcw;
  wire         do_pwr    = wr_acc && hit_pw;
  wire         do_ctl    = wr_acc && hit_ctl;
  wire         wdata_ok  = pwdata[0];

  // mask update: clear view, set view, soft reset
  always_comb begin
    nxt_mask = mask_ff;
    if (soft_rst_ff) begin
      nxt_mask = himfi_pkg::MASK_RESET; // [R7]
    end else if (do_clr) begin
      nxt_mask = mask_ff & ~(pwdata & himfi_pkg::MASK_VALID); // [R1] [R2] [R6] [R4]
    end else if (do_set) begin
      nxt_mask = mask_ff | (pwdata & himfi_pkg::MASK_VALID); // [R19] [R20]
    end
  end

  // period update: any write accepted at any frame, soft reset restores default
  always_comb begin
    nxt_period = period_ff;
    if (soft_rst_ff) begin
      nxt_period = himfi_pkg::PERIOD_RESET; // [R15]
    end else if (do_pwr) begin
      nxt_period = pwdata & himfi_pkg::PERIOD_VALID; // [R8] [R13] [R20]
    end
  end

  // frame countdown and packet budget counter
  wire [13:0] fi_field = period_ff[13:0]; // [R9]
  always_comb begin
    nxt_count = count_ff;
    nxt_pkt   = pkt_ff;
    if (soft_rst_ff) begin
      nxt_count = himfi_pkg::PERIOD_DEFAULT;
    end else if (bit_tick) begin
      if (count_ff == 14'h0000) begin
        nxt_count = fi_field; // [R18]
        nxt_pkt   = period_ff[30:16]; // [R10]
      end else begin
        nxt_count = count_ff - 14'h0001;
        nxt_pkt   = (pkt_ff > packet_used) ? pkt_ff - packet_used : 15'h0000;
      end
    end
  end

  // read mux; reserved bits already zero in storage
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (hit_mrd || hit_mcrd) begin
      nxt_rdata = mask_ff; // [R3]
    end else if (hit_prd) begin
      nxt_rdata = period_ff;
    end else if (hit_evt) begin
      nxt_rdata = {25'h0000000, event_flags};
    end
  end

  // register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff     <= himfi_pkg::MASK_RESET; // [R7]
      period_ff   <= himfi_pkg::PERIOD_RESET;
      count_ff    <= himfi_pkg::PERIOD_DEFAULT;
      pkt_ff      <= 15'h0000;
      soft_rst_ff <= 1'b0;
      begin_ff    <= 1'b0;
    end else begin
      mask_ff     <= nxt_mask;
      period_ff   <= nxt_period;
      count_ff    <= nxt_count;
      pkt_ff      <= nxt_pkt;
      soft_rst_ff <= do_ctl && wdata_ok;
      begin_ff    <= !soft_rst_ff && bit_tick && (count_ff == 14'h0000);
    end
  end

  // read data and error captured in setup, shown in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h00000000;
      err_ff   <= 1'b0;
    end else if (setup) begin
      rdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
      err_ff   <= bad_acc;
    end
  end

  // irq gating by flag, mask bit and master enable
  wire [6:0] live = event_flags & mask_ff[6:0] & 7'h7D; // [R5]
  assign irq_req  = mask_ff[himfi_pkg::MASTER_BIT] && (live != 7'h00); // [R17]

  assign prdata              = rdata_ff;
  assign pready              = 1'b1;
  assign pslverr             = psel && penable && err_ff;
  assign interrupt_mask      = mask_ff;
  assign frame_period_config = period_ff;
  assign frame_countdown     = count_ff;
  assign frame_begin         = begin_ff;
  assign packet_counter      = pkt_ff;

  // checks on the mask views
  a_clear_write: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    do_clr && !soft_rst_ff |=> (mask_ff & $past(pwdata) & himfi_pkg::MASK_VALID) == 32'h0)
    else $error("mask bit survived clear write");
  a_clear_keep: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    do_clr && !soft_rst_ff |=> (mask_ff & ~$past(pwdata)) == ($past(mask_ff) & ~$past(pwdata)))
    else $error("clear write disturbed zero bits");
  a_set_write: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    do_set && !soft_rst_ff |=> (mask_ff & $past(pwdata) & himfi_pkg::MASK_VALID)
      == ($past(pwdata) & himfi_pkg::MASK_VALID))
    else $error("mask bit not set");
  a_set_keep: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    do_set && !soft_rst_ff |=> ($past(mask_ff) & ~mask_ff) == 32'h0)
    else $error("set write cleared a mask bit");
  a_master_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    do_clr && pwdata[31] && !soft_rst_ff |=> !mask_ff[31])
    else $error("master enable survived clear write");

  // checks on the read side of the shared mask and the period register
  a_read_mask: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    setup && !pwrite && hit_mcrd |=> prdata == $past(mask_ff))
    else $error("clear view read differs from mask");
  a_read_shared: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    setup && !pwrite && hit_mrd |=> prdata == $past(mask_ff))
    else $error("set view read differs from mask");
  a_read_period: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    setup && !pwrite && hit_prd |=> prdata == $past(period_ff))
    else $error("period read differs from storage");

  // checks on the period register and on refused writes to the mask
  a_period_write: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    do_pwr && !soft_rst_ff |=> period_ff == ($past(pwdata) & himfi_pkg::PERIOD_VALID))
    else $error("period write not stored");
  a_period_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    !do_pwr && !soft_rst_ff |=> $stable(period_ff))
    else $error("period changed without a write");
  a_bad_refused: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    psel && penable && pwrite && bad_acc && !soft_rst_ff |=> $stable(mask_ff))
    else $error("refused write changed the mask");

  // checks on soft reset
  a_soft_period: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    soft_rst_ff |=> period_ff[13:0] == 14'h2EDF && mask_ff[31])
    else $error("soft reset did not restore defaults");
  a_soft_mask: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    soft_rst_ff |=> mask_ff == himfi_pkg::MASK_RESET)
    else $error("soft reset did not restore mask");

  // checks on interrupt gating
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
    irq_req |-> mask_ff[31] && ((event_flags & mask_ff[6:0]) != 7'h00))
    else $error("irq without enable");
  a_irq_master: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    mask_ff[31] && ((event_flags & mask_ff[6:0] & 7'h7D) != 7'h00) |-> irq_req)
    else $error("enabled event gave no irq");

  // checks on frame timing and reserved bits
  a_reload: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    bit_tick && count_ff == 14'h0000 && !soft_rst_ff |=> count_ff == $past(period_ff[13:0]))
    else $error("countdown not reloaded");
  a_count_down: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    bit_tick && count_ff != 14'h0000 && !soft_rst_ff |=> count_ff == $past(count_ff) - 14'h0001)
    else $error("countdown did not step");
  a_budget_load: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    frame_begin |-> pkt_ff == $past(period_ff[30:16]))
    else $error("budget not loaded at frame start");
  a_frame_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    frame_begin |-> $past(bit_tick) && $past(count_ff) == 14'h0000)
    else $error("frame start without reload");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    (mask_ff & ~himfi_pkg::MASK_VALID) == 32'h0 && period_ff[15:14] == 2'b00)
    else $error("reserved bit set");

endmodule : himfi_regs

/* File: testbench/himfi_regs_tb.sv */
// self-checking bench for the interrupt mask and frame period register bank
// assumes the design's own assertions; bench drives apb and core-side inputs directly
`timescale 1ns/1ns
module himfi_regs_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic        bit_tick = 1'b0;
  logic [6:0]  event_flags = 7'h00;
  logic [14:0] packet_used = 15'h0000;
  logic [31:0] prdata, interrupt_mask, rd, saved;
  logic        pready, pslverr, irq_req, frame_begin, er;
  logic [13:0] frame_countdown;
  logic [14:0] packet_counter;
  himfi_pkg::himfi_period_type frame_period_config;
  int          errors = 0;
  int          check_count = 0;
  int          n;

  // 50 MHz clock
  always #10 pclk = ~pclk;

  himfi_regs u_himfi_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_tick(bit_tick), .event_flags(event_flags),
    .packet_used(packet_used), .irq_req(irq_req), .interrupt_mask(interrupt_mask),
    .frame_period_config(frame_period_config), .frame_countdown(frame_countdown),
    .frame_begin(frame_begin), .packet_counter(packet_counter));

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // compare a value against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // settle after an edge
  task automatic tick();
    @(posedge pclk);
    #1;
  endtask : tick

  // change core event levels at an edge
  task automatic setev(input logic [6:0] v);
    @(posedge pclk);
    event_flags <= v;
    tick();
  endtask : setev

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // watchdog sized for three default frames plus register traffic
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h014, 0); chk(rd, 32'h80000000);
    chk(interrupt_mask, 32'h80000000);
    chk({18'h0, frame_countdown}, 32'h00002EDF);
    apb(0, 12'h034, 0); chk(rd, 32'h00002EDF);
    apb(1, 12'h210, 32'hFFFFFFFF); apb(0, 12'h014, 0); chk(rd, 32'h8000007D);
    apb(1, 12'h214, 32'h00000014); apb(0, 12'h014, 0); chk(rd, 32'h80000069);
    chk(interrupt_mask, 32'h80000069);
    apb(0, 12'h010, 0); chk(rd, 32'h80000069);
    apb(1, 12'h214, 32'h00000000); apb(0, 12'h014, 0); chk(rd, 32'h80000069);
    $display("mask clear view done");
    setev(7'h04); chk({31'h0, irq_req}, 32'h0);
    setev(7'h08); chk({31'h0, irq_req}, 32'h1);
    apb(1, 12'h214, 32'h80000000); tick(); chk({31'h0, irq_req}, 32'h0);
    apb(0, 12'h014, 0); chk(rd, 32'h00000069);
    setev(7'h00);
    $display("interrupt gating done");
    apb(1, 12'h234, 32'hFFFFFFFF); apb(0, 12'h034, 0); chk(rd, 32'hFFFF3FFF);
    chk(frame_period_config, 32'hFFFF3FFF);
    apb(1, 12'h234, 32'h00050003); apb(0, 12'h034, 0); chk(rd, 32'h00050003);
    apb(1, 12'h034, 32'h12345678); chk({31'h0, er}, 32'h1);
    apb(0, 12'h034, 0); chk(rd, 32'h00050003);
    apb(0, 12'h0FC, 0); chk({31'h0, er}, 32'h1); chk(rd, 32'h0);
    $display("period register done");
    @(posedge pclk);
    bit_tick <= 1'b1;
    n = 0;
    while (frame_begin !== 1'b1 && n < 13000) begin tick(); n++; end
    chk({17'h0, packet_counter}, 32'h00000005);
    tick();
    n = 1;
    while (frame_begin !== 1'b1 && n < 50) begin tick(); n++; end
    chk(n, 32'h00000004);
    @(posedge pclk);
    bit_tick <= 1'b0;
    $display("frame timing done");
    apb(1, 12'h234, 32'h80050003); apb(0, 12'h034, 0); chk(rd, 32'h80050003);
    saved = rd;
    apb(1, 12'h300, 32'h00000001);
    repeat (2) @(posedge pclk);
    apb(0, 12'h034, 0); chk(rd, 32'h00002EDF);
    chk({18'h0, frame_countdown}, 32'h00002EDF);
    apb(0, 12'h014, 0); chk(rd, 32'h80000000);
    apb(1, 12'h234, saved); apb(0, 12'h034, 0); chk(rd, 32'h80050003);
    $display("soft reset done");
    tally_and_finish();
  end
endmodule : himfi_regs_tb
